// file: core/tpdca_top.sv
`timescale 1ns/10ps
module tpdca_top
   import tpdca_pkg::*;
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        NRST,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // TDM data clock and frame sync, two-way
   input  wire logic        DCL_IN,
   output logic             DCL_OUT,
   output logic             DCL_OE,
   input  wire logic        FSYNC_IN,
   output logic             FSYNC_OUT,
   output logic             FSYNC_OE,
   // TDM serial data and timeslot enable
   input  wire logic        DATA_IN,
   output logic             DATA_OUT,
   output logic             DATA_OE,
   output logic             TSLOT_EN_N,
   // Dedicated D channel port
   output logic             DCH_PORT_CLK,
   input  wire logic        DCH_PORT_IN,
   output logic             DCH_PORT_OUT,
   // Activation logic and line side, same clock
   input  wire logic        ACT_DONE,
   input  wire logic        ACT_EVENT,
   input  wire logic [3:0]  ACT_STATUS,
   input  wire logic [1:0]  LINE_DCH_RX,
   output logic      [1:0]  LINE_DCH_TX,
   // Interrupt
   output logic             IRQ
);

   tpdca_state_s s;
   tpdca_state_s n;
   tpdca_slot_s  sl_r;
   tpdca_slot_s  sl_f;
   logic         rise;
   logic         fall;
   logic         fs_lvl;
   logic         acc_on;
   logic         wr_done;
   logic         rd_done;
   logic         byte_evt;
   logic         adj_now;
   logic         drive;
   logic [8:0]   cnt_n;
   logic [7:0]   half;
   logic [8:0]   flen;
   logic [8:0]   corr;

   function automatic tpdca_slot_s slot_of(input logic [8:0] c, input logic f10);
      tpdca_slot_s r;
      r.kind = SLOT_NONE;
      r.idx  = c[2:0];
      if (c < B_LEN) begin
         r.kind = SLOT_B1;
      end else if (!f10) begin
         if (c < D8_FIRST) begin
            r.kind = SLOT_B2;
         end else if (c < D8_FIRST + D_LEN) begin
            r.kind = SLOT_D;
         end
      end else if (c < D10_FIRST + D_LEN) begin
         r.kind = SLOT_D;
      end else if (c < B2_10_FIRST + B_LEN) begin
         r.kind = SLOT_B2;
         r.idx  = 3'(c - B2_10_FIRST);
      end
      return r;
   endfunction

   always_comb begin
      n        = s;
      byte_evt = 1'b0;
      rise     = 1'b0;
      fall     = 1'b0;
      drive    = 1'b0;
      wr_done  = PSEL & PENABLE & PWRITE & s.pready;
      rd_done  = PSEL & PENABLE & ~PWRITE & s.pready;
      acc_on   = s.ctrl[CTRL_MCU] & s.ctrl[CTRL_DACC] & s.ctrl[CTRL_TRANSP] & ACT_DONE; // R1 R2
      case (s.rate)
         RATE_512K: begin
            half = HALF_512K;
            flen = FLEN_512K;
            corr = CORR_512K;                                    // R9
         end
         RATE_2048K: begin
            half = HALF_2048K;
            flen = FLEN_2048K;
            corr = CORR_FAST;                                    // R7
         end
         default: begin
            half = HALF_2560K;
            flen = FLEN_2560K;
            corr = CORR_FAST;                                    // R7
         end
      endcase

      // Synchronisers for pins from the partner's clock domain
      n.dcl_s   = {s.dcl_s[1:0], DCL_IN};
      n.fs_s    = {s.fs_s[0], FSYNC_IN};
      n.din_s   = {s.din_s[0], DATA_IN};
      n.dchan_port_serial_in_s = {s.dchan_port_serial_in_s[0], DCH_PORT_IN};

      // Pulse numbering restarts right after the sync
      if (s.arm) begin
         cnt_n = '0;                                             // R8
      end else if (s.cnt == CNT_MAX) begin
         cnt_n = s.cnt;
      end else begin
         cnt_n = s.cnt + 9'h001;
      end
      adj_now = (cnt_n == corr) && (s.adj_left != 2'b00);        // R6

      // Master clock divider, or edge detection on the slave clock
      if (s.master) begin
         if (s.div == 8'h00) begin
            n.gen_dcl = ~s.gen_dcl;
            if (!s.gen_dcl) begin
               rise = 1'b1;
               if (adj_now && s.adj_long) begin
                  n.div = half + ADJ_CYC - 8'h01;                // R6
               end else if (adj_now) begin
                  n.div = half - ADJ_CYC - 8'h01;                // R6
               end else begin
                  n.div = half - 8'h01;                          // R10
               end
            end else begin
               fall  = 1'b1;
               n.div = half - 8'h01;                             // R10
            end
         end else begin
            n.div = s.div - 8'h01;
         end
         fs_lvl = s.gen_fs;
      end else begin
         // Partner clock must be slow enough for the 50 MHz sampler
         rise    = s.dcl_s[1] & ~s.dcl_s[2];                     // R12
         fall    = s.dcl_s[2] & ~s.dcl_s[1];
         n.gen_dcl = 1'b0;
         n.div   = 8'h00;
         fs_lvl  = s.fs_s[1];
      end

      // APB register writes
      if (wr_done) begin
         if (PADDR == REG_CTRL) begin
            n.ctrl = PWDATA[3:0];
         end else if (PADDR == REG_CFG) begin
            n.rate   = tpdca_rate_e'(PWDATA[1:0]);
            n.master = PWDATA[CFG_MASTER];
            n.fmt10  = PWDATA[CFG_FMT10];
         end else if (PADDR == REG_TX_B) begin
            n.tx_b1 = PWDATA[7:0];
            n.tx_b2 = PWDATA[15:8];
         end else if (PADDR == REG_OVERLAY) begin
            n.ov_tx = PWDATA[7:0];                               // R2
         end else if (PADDR == REG_IRQ_EN) begin
            n.irq_en = PWDATA[1:0];
         end else if (PADDR == REG_IRQ_CLR) begin
            n.irq_st = s.irq_st & ~PWDATA[1:0];
         end else if (PADDR == REG_ADJ) begin
            n.adj_req = PWDATA[1:0];
         end
      end

      // Read side effects
      if (rd_done && PADDR == REG_OVERLAY) begin
         n.ov_unread = 1'b0;
         if (s.act_held) begin
            n.act_held        = 1'b0;
            n.irq_st[IRQ_ACT] = 1'b1;                            // R5
         end
      end
      if (rd_done && PADDR == REG_NIBBLE) begin
         n.nib_hold = 1'b0;
      end
      if (!n.nib_hold) begin
         n.nibble = ACT_STATUS;
      end

      // Rising edge of the data clock: launch outputs
      sl_r = slot_of(cnt_n, s.fmt10);
      if (rise) begin
         n.cnt    = cnt_n;
         n.arm    = 1'b0;
         n.gen_fs = s.master & (cnt_n == flen - 9'h001);
         if (s.arm) begin
            n.rx_b1 = s.rxw_b1;
            n.rx_b2 = s.rxw_b2;
            n.drx   = LINE_DCH_RX;
            if (s.adj_req != 2'b00 && s.adj_left == 2'b00) begin
               n.adj_left = 2'b10;                               // R6
               n.adj_long = s.adj_req[ADJ_LONG];
               n.adj_req  = 2'b00;
            end
            if (acc_on) begin
               n.line_tx = s.ovt_sh[7:6];                        // R1
               n.ovt_sh  = {s.ovt_sh[5:0], 2'b00};
               n.ovr_sh  = {s.ovr_sh[5:0], LINE_DCH_RX};
               n.bfrm    = s.bfrm + 2'b01;
               if (s.bfrm == BYTE_FRAMES_M1) begin
                  byte_evt = 1'b1;                               // R4
                  n.ov_rx  = {s.ovr_sh[5:0], LINE_DCH_RX};       // R2
                  n.ovt_sh = s.ov_tx;
               end
            end else begin
               n.line_tx = s.dcur;
               n.bfrm    = 2'b00;
               n.ovt_sh  = s.ov_tx;
            end
         end
         if (adj_now) begin
            n.adj_left = s.adj_left - 2'b01;
         end
         drive = (sl_r.kind == SLOT_B1) || (sl_r.kind == SLOT_B2) ||
                 (sl_r.kind == SLOT_D && !acc_on && !s.ctrl[CTRL_DPORT]); // R1 R11
         n.dout_oe = drive;                                      // R13
         case (sl_r.kind)
            SLOT_B1: n.dout = s.tx_b1[~sl_r.idx];
            SLOT_B2: n.dout = s.tx_b2[~sl_r.idx];
            SLOT_D:  n.dout = drive & s.drx[~sl_r.idx[0]];
            default: n.dout = 1'b0;
         endcase
         if (drive) begin
            n.timeslot_enable_out_n = 1'b0;                                     // R15
         end
         n.dchan_port_clock = (sl_r.kind == SLOT_D) && !acc_on;            // R16
         if (n.dchan_port_clock) begin
            n.dchan_port_serial_out = s.drx[~sl_r.idx[0]];                      // R16
         end
      end

      // Falling edge: sample inputs, end enables
      sl_f = slot_of(s.cnt, s.fmt10);
      if (fall) begin
         n.dchan_port_clock = 1'b0;
         n.timeslot_enable_out_n = ~s.dout_oe;                                  // R15
         if (fs_lvl) begin
            n.arm = 1'b1;
         end
         case (sl_f.kind)
            SLOT_B1: n.rxw_b1 = {s.rxw_b1[6:0], s.din_s[1]};     // R14
            SLOT_B2: n.rxw_b2 = {s.rxw_b2[6:0], s.din_s[1]};     // R14
            SLOT_D: begin
               if (!acc_on) begin
                  n.dcur[~sl_f.idx[0]] = s.ctrl[CTRL_DPORT] ? s.dchan_port_serial_in_s[1] : s.din_s[1]; // R16
               end
            end
            default: n.dcur = s.dcur;
         endcase
      end

      // Byte arrival and activation events; sets win over clears
      if (byte_evt) begin
         n.ov_unread       = 1'b1;                               // R17
         n.irq_st[IRQ_DCH] = 1'b1;                               // R4
         if (s.irq_en[IRQ_DCH] && s.ctrl[CTRL_DACC]) begin
            n.nibble   = NIBBLE_DCH;                             // R3
            n.nib_hold = 1'b1;
         end
      end
      if (ACT_EVENT) begin
         if (n.ov_unread) begin
            n.act_held = 1'b1;                                   // R5
         end else begin
            n.irq_st[IRQ_ACT] = 1'b1;
         end
      end
      n.irq = |(n.irq_st & n.irq_en);

      // APB setup phase: answer in the following access cycle
      if (PSEL && !PENABLE) begin
         n.pready  = 1'b1;
         n.pslverr = 1'b0;
         n.prdata  = 32'h0000_0000;
         if (PADDR == REG_CTRL) begin
            n.prdata[3:0] = s.ctrl;
         end else if (PADDR == REG_CFG) begin
            n.prdata[3:0] = {s.fmt10, s.master, s.rate};
         end else if (PADDR == REG_TX_B) begin
            n.prdata[15:0] = {s.tx_b2, s.tx_b1};
         end else if (PADDR == REG_RX_B) begin
            n.prdata[15:0] = {s.rx_b2, s.rx_b1};
         end else if (PADDR == REG_OVERLAY) begin
            n.prdata[7:0] = acc_on ? s.ov_rx : 8'h00;            // R2
         end else if (PADDR == REG_NIBBLE) begin
            n.prdata[3:0] = s.nibble;
         end else if (PADDR == REG_IRQ_ST) begin
            n.prdata[1:0] = s.irq_st;
         end else if (PADDR == REG_IRQ_EN) begin
            n.prdata[1:0] = s.irq_en;
         end else if (PADDR == REG_IRQ_CLR) begin
            n.prdata = 32'h0000_0000;
         end else if (PADDR == REG_ADJ) begin
            n.prdata[3:0] = {s.adj_left, s.adj_req};
         end else begin
            n.pslverr = 1'b1;
         end
      end else if (PSEL && PENABLE && s.pready) begin
         n.pready  = 1'b0;
         n.pslverr = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         s          <= '0;
         s.timeslot_enable_out_n   <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign PRDATA       = s.prdata;
   assign PREADY       = s.pready;
   assign PSLVERR      = s.pslverr;
   assign DCL_OUT      = s.gen_dcl;
   assign DCL_OE       = s.master;
   assign FSYNC_OUT    = s.gen_fs;
   assign FSYNC_OE     = s.master;
   assign DATA_OUT     = s.dout;
   assign DATA_OE      = s.dout_oe;
   assign TSLOT_EN_N   = s.timeslot_enable_out_n;
   assign DCH_PORT_CLK = s.dchan_port_clock;
   assign DCH_PORT_OUT = s.dchan_port_serial_out;
   assign LINE_DCH_TX  = s.line_tx;
   assign IRQ          = s.irq;

   // Helpers watched only by the checks below
   logic [7:0] hi_cnt;
   logic       hi_adj;
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         hi_cnt <= 8'h00;
         hi_adj <= 1'b0;
      end else if (rise) begin
         hi_cnt <= 8'h01;
         hi_adj <= adj_now;
      end else if (s.gen_dcl) begin
         hi_cnt <= hi_cnt + 8'h01;
      end
   end

   chk_high_nominal: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R10
      (s.master && fall && !hi_adj) |-> (hi_cnt == half))
      else $error("Data clock high phase off nominal");
   chk_high_adjusted: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R6
      (s.master && fall && hi_adj) |->
      (hi_cnt == (s.adj_long ? half + ADJ_CYC : half - ADJ_CYC)))
      else $error("Corrected high phase has wrong length");
   chk_corr_pulse: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R7
      (rise && adj_now) |-> (cnt_n == ((s.rate == RATE_512K) ? CORR_512K : CORR_FAST)))
      else $error("Correction on wrong pulse");
   chk_pulse_zero: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R8
      (rise && s.arm) |=> (s.cnt == 9'h000))
      else $error("Pulse count not zero after sync");
   chk_dout_rise: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R13
      $changed(s.dout_oe) |-> $past(rise))
      else $error("Data enable moved off a rising edge");
   chk_timeslot_enable_out_edges: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R15
      ($fell(s.timeslot_enable_out_n) |-> $past(rise)) and ($rose(s.timeslot_enable_out_n) |-> $past(fall)))
      else $error("Timeslot enable moved on wrong edge");
   chk_timeslot_enable_out_align: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R11
      $rose(s.dout_oe) |-> !s.timeslot_enable_out_n)
      else $error("Timeslot enable not aligned with data");
   chk_dchan_port_clock_rise: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R16
      $rose(s.dchan_port_clock) |-> ($past(rise) && !$past(acc_on)))
      else $error("D port clock rose without data clock rise");
   chk_nibble_load: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R3
      (byte_evt && s.irq_en[IRQ_DCH] && s.ctrl[CTRL_DACC]) |=> (s.nibble == NIBBLE_DCH))
      else $error("Nibble not loaded on byte arrival");
   chk_act_defer: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R5
      (ACT_EVENT && s.ov_unread && !rd_done && !s.irq_st[IRQ_ACT]) |=>
      (!s.irq_st[IRQ_ACT] && s.act_held))
      else $error("Activation event not held behind D byte");
   chk_access_tdm: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R1
      (rise && acc_on && sl_r.kind == SLOT_D) |=> (!s.dout_oe && !s.dchan_port_clock))
      else $error("D slot driven during host access");
   chk_byte_irq: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R4
      byte_evt |-> (acc_on && s.arm && s.bfrm == BYTE_FRAMES_M1))
      else $error("D byte event off the four frame period");

endmodule

// file: core/tpdca_pkg.sv
// What this block does
// R1: Access mode routes line D channel bits to the host instead of port pins or TDM.
// R2: Overlay register carries D bytes only after activation, transparency and access bit.
// R3: With D interrupt enabled and access bit set, a new byte loads nibble 1111.
// R4: D byte interrupt recurs every 500 us while host access is active.
// R5: Activation event meeting an unread D byte is held until the overlay is read.
// R6: Master timing stretches or shrinks one clock high phase on two successive frames.
// R7: At 2.048 or 2.56 MHz the corrected pulse is number 249.
// R8: Pulse zero is the data clock right after the frame sync.
// R9: At 512 kHz the corrected pulse is number 59.
// R10: Master data clock keeps near 50 percent duty except the corrected pulse.
// R11: Timeslot enable marks B1, B2 and D slots (D only without host access or D port mode), aligned with serial output data.
// R12: In slave timing the partner supplies a 256 kHz to 4.096 MHz data clock.
// R13: Serial output and its enable change after data clock rising edges.
// R14: Serial input is sampled at data clock falling edges.
// R15: Timeslot enable falls after a rising edge and rises after a falling edge.
// R16: D port clock rises with the data clock; out on rise, in on fall.
// R17: Host reads the overlay each 500 us period so no byte is lost.
package tpdca_pkg;

   localparam int CORE_KHZ     = 50000;
   localparam int ADJ_NS       = 48;
   localparam int ADJ_CYC_I    = (ADJ_NS * CORE_KHZ / 1000000 < 1) ? 1 :
                                 ADJ_NS * CORE_KHZ / 1000000;
   localparam logic [7:0] ADJ_CYC = 8'(ADJ_CYC_I);
   localparam int FRAME_US     = 125;
   localparam int DCHAN_IRQ_US = 500;
   localparam logic [1:0] BYTE_FRAMES_M1 = 2'(DCHAN_IRQ_US / FRAME_US - 1);

   // Generated clock only approximates the nominal rates from a 50 MHz core
   localparam logic [7:0] HALF_512K  = 8'(CORE_KHZ / (2 * 512));
   localparam logic [7:0] HALF_2048K = 8'(CORE_KHZ / (2 * 2048));
   localparam logic [7:0] HALF_2560K = 8'(CORE_KHZ / (2 * 2560));
   localparam logic [8:0] FLEN_512K  = 9'h040;
   localparam logic [8:0] FLEN_2048K = 9'h100;
   localparam logic [8:0] FLEN_2560K = 9'h140;
   localparam logic [8:0] CORR_512K  = 9'h03B;
   localparam logic [8:0] CORR_FAST  = 9'h0F9;
   localparam logic [8:0] CNT_MAX    = 9'h1FF;

   // Slot layout in pulse numbers
   localparam logic [8:0] B_LEN      = 9'h008;
   localparam logic [8:0] D_LEN      = 9'h002;
   localparam logic [8:0] D8_FIRST   = 9'h010;
   localparam logic [8:0] D10_FIRST  = 9'h008;
   localparam logic [8:0] B2_10_FIRST = 9'h00A;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_CFG     = 8'h04;
   localparam logic [7:0] REG_TX_B    = 8'h08;
   localparam logic [7:0] REG_RX_B    = 8'h0C;
   localparam logic [7:0] REG_OVERLAY = 8'h10;
   localparam logic [7:0] REG_NIBBLE  = 8'h14;
   localparam logic [7:0] REG_IRQ_ST  = 8'h18;
   localparam logic [7:0] REG_IRQ_EN  = 8'h1C;
   localparam logic [7:0] REG_IRQ_CLR = 8'h20;
   localparam logic [7:0] REG_ADJ     = 8'h24;

   localparam int CTRL_TRANSP = 0;
   localparam int CTRL_DACC   = 1;
   localparam int CTRL_MCU    = 2;
   localparam int CTRL_DPORT  = 3;
   localparam int CFG_MASTER  = 2;
   localparam int CFG_FMT10   = 3;
   localparam int IRQ_DCH     = 0;
   localparam int IRQ_ACT     = 1;
   localparam int ADJ_LONG    = 0;
   localparam int ADJ_SHORT   = 1;
   localparam logic [3:0] NIBBLE_DCH = 4'hF;

   typedef enum logic [1:0] {
      RATE_512K  = 2'b00,
      RATE_2048K = 2'b01,
      RATE_2560K = 2'b10
   } tpdca_rate_e;

   typedef enum logic [1:0] {
      SLOT_NONE = 2'b00,
      SLOT_B1   = 2'b01,
      SLOT_B2   = 2'b10,
      SLOT_D    = 2'b11
   } tpdca_slot_e;

   typedef struct packed {
      tpdca_slot_e kind;
      logic [2:0]  idx;
   } tpdca_slot_s;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [3:0]  ctrl;
      tpdca_rate_e rate;
      logic        master;
      logic        fmt10;
      logic [7:0]  tx_b1;
      logic [7:0]  tx_b2;
      logic [7:0]  rx_b1;
      logic [7:0]  rx_b2;
      logic [7:0]  rxw_b1;
      logic [7:0]  rxw_b2;
      logic [7:0]  ov_tx;
      logic [7:0]  ov_rx;
      logic [7:0]  ovt_sh;
      logic [7:0]  ovr_sh;
      logic [1:0]  bfrm;
      logic        ov_unread;
      logic        act_held;
      logic [3:0]  nibble;
      logic        nib_hold;
      logic [1:0]  irq_st;
      logic [1:0]  irq_en;
      logic        irq;
      logic [1:0]  adj_req;
      logic [1:0]  adj_left;
      logic        adj_long;
      logic [2:0]  dcl_s;
      logic [1:0]  fs_s;
      logic [1:0]  din_s;
      logic [1:0]  dchan_port_serial_in_s;
      logic [7:0]  div;
      logic        gen_dcl;
      logic        gen_fs;
      logic [8:0]  cnt;
      logic        arm;
      logic        dout;
      logic        dout_oe;
      logic        timeslot_enable_out_n;
      logic        dchan_port_clock;
      logic        dchan_port_serial_out;
      logic [1:0]  drx;
      logic [1:0]  dcur;
      logic [1:0]  line_tx;
   } tpdca_state_s;

endpackage

// file: sim/tpdca_partner.sv
`timescale 1ns/10ps
module tpdca_partner (
   // Link pins
   output logic             tdm_data_clock,
   output logic             fsync,
   output logic             din,
   input  wire logic        dout,
   input  wire logic        dout_oe,
   // Bench side
   input  wire logic [15:0] rx_word,
   output logic      [15:0] cap_word
);
   int          pulse = 31;
   logic [15:0] sh    = 16'h0000;
   initial begin
      tdm_data_clock = 1'b0;
      fsync = 1'b0;
      din = 1'b0;
      cap_word = 16'h0000;
      // Backplane clock runs free between frames
      forever #80 tdm_data_clock = ~tdm_data_clock;
   end
   always @(posedge tdm_data_clock) begin
      if (pulse < 16) begin
         sh = {sh[14:0], dout_oe & dout};
      end
      if (pulse == 15) begin
         cap_word = sh;
      end
      pulse = (pulse + 1) % 32;
      // Sync spans a falling edge so the next rise is pulse 0
      fsync = (pulse == 31);
      // Changed on the rise, so it holds well past the sampling fall
      din = (pulse < 16) ? rx_word[15 - pulse] : ~din;
   end
endmodule

// file: sim/tdm_port_dchannel_access_bench.sv
`timescale 1ns/10ps
module tdm_port_dchannel_access_bench;
   import tpdca_pkg::*;
   logic        clk, nrst, psel, pen, pwr, act_done, act_ev, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd, prdata, e;
   logic        pready, pslverr, dcl_o, dcl_oe, fs_o, fs_oe;
   logic        dout, dout_oe, timeslot_enable_out_n, irq, p_dcl, p_fs, p_din;
   logic [1:0]  line_rx;
   logic [15:0] rx_word, cap, tx;
   int          fails, checks_done, cyc, n, fs_cnt, t1;

   tpdca_top dut (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .DCL_IN(dcl_oe ? dcl_o : p_dcl),
      .DCL_OUT(dcl_o), .DCL_OE(dcl_oe), .FSYNC_IN(fs_oe ? fs_o : p_fs),
      .FSYNC_OUT(fs_o), .FSYNC_OE(fs_oe), .DATA_IN(p_din), .DATA_OUT(dout),
      .DATA_OE(dout_oe), .TSLOT_EN_N(timeslot_enable_out_n), .DCH_PORT_CLK(),
      .DCH_PORT_IN(p_din), .DCH_PORT_OUT(), .ACT_DONE(act_done),
      .ACT_EVENT(act_ev), .ACT_STATUS(4'h3), .LINE_DCH_RX(line_rx),
      .LINE_DCH_TX(), .IRQ(irq));
   tpdca_partner far_end (.tdm_data_clock(p_dcl), .fsync(p_fs), .din(p_din), .dout(dout),
      .dout_oe(dout_oe), .rx_word(rx_word), .cap_word(cap));

   task automatic chk(input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         fails++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wait_irq;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk(32'h1, {31'h0, irq});
   endtask
   task automatic end_of_test;
      $display("checks=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge p_fs) fs_cnt++;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         end_of_test();
      end
   end

   initial begin
      {nrst, psel, pen, pwr, act_done, act_ev} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      line_rx = 2'b10;
      rx_word = 16'h0;
      fails = 0;
      checks_done = 0;
      cyc = 0;
      fs_cnt = 0;
      void'($urandom(89));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk(32'h1, {31'h0, timeslot_enable_out_n});
      chk(32'h0, {31'h0, irq});
      e = $urandom_range(2);
      apb(1'b1, REG_CFG, e);
      apb(1'b0, REG_CFG, 32'h0);
      chk(e, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk(32'h1, {31'h0, err});
      chk(32'h0, rd);
      $display("test registers done");
      apb(1'b1, REG_CFG, 32'h0);
      tx = 16'($urandom);
      rx_word <= 16'($urandom);
      apb(1'b1, REG_TX_B, {16'h0, tx});
      repeat (3) @(posedge p_fs);
      chk({16'h0, tx[7:0], tx[15:8]}, {16'h0, cap});
      apb(1'b0, REG_RX_B, 32'h0);
      chk({16'h0, rx_word[7:0], rx_word[15:8]}, rd);
      // Ten-bit layout puts the D pair between B1 and B2
      apb(1'b1, REG_CFG, 32'h8);
      repeat (3) @(posedge p_fs);
      chk({16'h0, tx[7:0], line_rx, tx[15:10]}, {16'h0, cap});
      $display("test tdm slots done");
      act_done <= 1'b1;
      apb(1'b1, REG_CTRL, 32'h7);
      apb(1'b1, REG_IRQ_EN, 32'h3);
      wait_irq();
      t1 = fs_cnt;
      apb(1'b0, REG_IRQ_ST, 32'h0);
      chk(32'h1, rd);
      apb(1'b0, REG_NIBBLE, 32'h0);
      chk({28'h0, NIBBLE_DCH}, rd);
      apb(1'b1, REG_IRQ_CLR, 32'h1);
      repeat (2) @(posedge clk);
      chk(32'h0, {31'h0, irq});
      wait_irq();
      chk(32'd4, 32'(fs_cnt - t1));
      act_ev <= 1'b1;
      @(posedge clk);
      act_ev <= 1'b0;
      apb(1'b0, REG_IRQ_ST, 32'h0);
      chk(32'h1, rd);
      e = 0;
      for (n = 0; n < 4; n++) e = (e << 2) | 32'(line_rx);
      apb(1'b0, REG_OVERLAY, 32'h0);
      chk(e, rd);
      apb(1'b0, REG_IRQ_ST, 32'h0);
      chk(32'h3, rd);
      $display("test host d channel done");
      apb(1'b1, REG_CFG, 32'h6);
      repeat (2) @(posedge clk);
      chk(32'h3, {30'h0, dcl_oe, fs_oe});
      // Lengthen request must be used up on the two following frames
      apb(1'b1, REG_ADJ, 32'h1);
      repeat (4) @(posedge fs_o);
      apb(1'b0, REG_ADJ, 32'h0);
      chk(32'h0, rd);
      $display("test master done");
      end_of_test();
   end
endmodule
